// file: core/boot_loader_pkg.sv
// Constants shared by the boot mode selector and program loader
package boot_loader_pkg;
    localparam logic [3:0]  MODE_EXPANDED   = 4'h8;
    localparam logic [3:0]  MODE_BYTE_MEM   = 4'h9;
    localparam logic [3:0]  MODE_SERIAL     = 4'ha;
    localparam logic [3:0]  MODE_HOST       = 4'hc;
    localparam logic [23:0] VEC_EXPANDED    = 24'h008000;
    localparam logic [23:0] VEC_BOOTSTRAP   = 24'hff0000;
    localparam logic [23:0] BYTE_MEM_BASE   = 24'hd00000;
    localparam logic [4:0]  EXT_WAIT_STATES = 5'h1f;
    localparam int          CLK_HZ          = 25000000;
    localparam int          PROGRAM_RAM_AW         = 10;
    localparam int          BYTES_PER_WORD  = 3;
    localparam int          OVERSAMPLE      = 16;
    localparam int          UART_BITS       = 8;
    // Memory access type codes
    localparam logic [1:0]  ACC_NONE        = 2'h0;
    localparam logic [1:0]  ACC_SRAM        = 2'h1;
    // Wishbone register offsets
    localparam logic [3:0]  REG_STATUS      = 4'h0;
    localparam logic [3:0]  REG_VECTOR      = 4'h4;
    localparam logic [3:0]  REG_COUNT       = 4'h8;
    localparam logic [3:0]  REG_LOADADDR    = 4'hc;
    // Status bit positions
    localparam int          ST_DONE_BIT     = 0;
    localparam int          ST_MODE_LSB     = 4;
    localparam int          ST_EARLY_BIT    = 8;
endpackage : boot_loader_pkg

// file: core/program_ram.sv
// Program RAM with registered read port
`timescale 1ns/1ps
`default_nettype none
module program_ram (
    // Clock
    input  wire logic                                   clk_sys,
    // Write port
    input  wire logic                                   wr_en,
    input  wire logic [boot_loader_pkg::PROGRAM_RAM_AW-1:0]    wr_addr,
    input  wire logic [23:0]                            wr_data,
    // Read port
    input  wire logic [boot_loader_pkg::PROGRAM_RAM_AW-1:0]    rd_addr,
    output logic      [23:0]                            rd_data
);
    logic [23:0] mem [0:(1<<boot_loader_pkg::PROGRAM_RAM_AW)-1];

    always_ff @(posedge clk_sys) begin
        if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
        rd_data <= mem[rd_addr];
    end
endmodule : program_ram
`default_nettype wire

// file: core/boot_mode_program_loader.sv
// Boot mode capture and program bootstrap loader
// What this block does
// - Mode 8 jumps straight to 008000
// - Mode 8 uses SRAM cycles, 31 waits
// - Mode 9 loads bytes from D00000, low byte
// - Byte boot uses strobe one, 31 waits
// - Count, address, then program word bytes
// - Each quantity arrives low byte first
// - Three bytes form word, stored consecutively
// - After last word, run from load address
// - Mode A loads through async serial port
// - Serial sends count, address, word bytes
// - Serial framing 8N1 both ways
// - Echo every received serial byte while the two-entry echo buffer has room; a byte that finds it full is dropped
// - Mode C loads over ISA host port
// - Host writes count, address, then words
// - Host flag zero ends load early
//
// The placing of the registers and register access over Wishbone are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module boot_mode_program_loader (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        rst,
    // Mode pins
    input  wire logic        mode_select_bit0,
    input  wire logic        mode_select_bit1,
    input  wire logic        mode_select_bit2,
    input  wire logic        mode_select_bit3,
    // External byte memory
    output logic [23:0]      ext_addr,
    output logic             ext_rd,
    output logic             address_attribute_strobe_one,
    output logic [1:0]       ext_access_type,
    output logic [4:0]       ext_wait_states,
    input  wire logic [7:0]  ext_data,
    input  wire logic        ext_ack,
    // Async serial port
    input  wire logic        serial_clk,
    input  wire logic        serial_rxd,
    output logic             serial_txd,
    // Host port
    input  wire logic [23:0] host_data,
    input  wire logic        host_valid,
    output logic             host_ready,
    input  wire logic        host_flag_zero,
    output logic             host_port_isa,
    // Core start
    output logic             core_run,
    output logic [23:0]      core_start_addr,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [31:0] wb_dat_i,
    input  wire logic [3:0]  wb_sel_i,
    output logic [31:0]      wb_dat_o,
    output logic             wb_ack_o
);
    typedef enum logic [2:0] {
        ST_CAPTURE = 3'h0,
        ST_COUNT   = 3'h1,
        ST_ADDR    = 3'h2,
        ST_WORDS   = 3'h3,
        ST_RUN     = 3'h4,
        ST_IDLE    = 3'h5
    } load_state_t;

    // Synchronisers: pins, serial clock, rxd, host flag
    logic [2:0] sync_mode0_ff, sync_mode1_ff, sync_mode2_ff, sync_mode3_ff;
    logic [2:0] sync_sclk_ff, sync_rxd_ff, sync_hf0_ff;
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sync_mode0_ff <= 3'h0;
            sync_mode1_ff <= 3'h0;
            sync_mode2_ff <= 3'h0;
            sync_mode3_ff <= 3'h0;
            sync_sclk_ff  <= 3'h0;
            sync_rxd_ff   <= 3'h7;
            sync_hf0_ff   <= 3'h0;
        end else begin
            sync_mode0_ff <= {sync_mode0_ff[1:0], mode_select_bit0};
            sync_mode1_ff <= {sync_mode1_ff[1:0], mode_select_bit1};
            sync_mode2_ff <= {sync_mode2_ff[1:0], mode_select_bit2};
            sync_mode3_ff <= {sync_mode3_ff[1:0], mode_select_bit3};
            sync_sclk_ff  <= {sync_sclk_ff[1:0], serial_clk};
            sync_rxd_ff   <= {sync_rxd_ff[1:0], serial_rxd};
            sync_hf0_ff   <= {sync_hf0_ff[1:0], host_flag_zero};
        end
    end
    // Stage 2 and 3 agree before a change counts
    logic sclk_lvl_ff, rxd_lvl_ff, hf0_lvl_ff;
    logic nxt_sclk_lvl, nxt_rxd_lvl, nxt_hf0_lvl;
    always_comb begin
        nxt_sclk_lvl = (sync_sclk_ff[1] == sync_sclk_ff[2]) ? sync_sclk_ff[2] : sclk_lvl_ff;
        nxt_rxd_lvl  = (sync_rxd_ff[1] == sync_rxd_ff[2]) ? sync_rxd_ff[2] : rxd_lvl_ff;
        nxt_hf0_lvl  = (sync_hf0_ff[1] == sync_hf0_ff[2]) ? sync_hf0_ff[2] : hf0_lvl_ff;
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            sclk_lvl_ff <= 1'b0;
            rxd_lvl_ff  <= 1'b1;
            hf0_lvl_ff  <= 1'b0;
        end else begin
            sclk_lvl_ff <= nxt_sclk_lvl;
            rxd_lvl_ff  <= nxt_rxd_lvl;
            hf0_lvl_ff  <= nxt_hf0_lvl;
        end
    end
    logic sclk_rise;
    assign sclk_rise = nxt_sclk_lvl & ~sclk_lvl_ff;

    // Serial receiver, 16 ticks per bit on the outside clock
    logic [3:0] rx_tick_ff, nxt_rx_tick;
    logic [3:0] rx_bit_ff, nxt_rx_bit;
    logic [7:0] rx_sh_ff, nxt_rx_sh;
    logic       rx_busy_ff, nxt_rx_busy;
    logic       rx_strobe;
    always_comb begin
        nxt_rx_tick = rx_tick_ff;
        nxt_rx_bit  = rx_bit_ff;
        nxt_rx_sh   = rx_sh_ff;
        nxt_rx_busy = rx_busy_ff;
        rx_strobe   = 1'b0;
        if (sclk_rise) begin
            if (!rx_busy_ff) begin
                if (!rxd_lvl_ff) begin
                    nxt_rx_busy = 1'b1;
                    nxt_rx_tick = 4'h1;
                    nxt_rx_bit  = 4'h0;
                end
            end else begin
                nxt_rx_tick = rx_tick_ff + 4'h1;
                if (rx_tick_ff == 4'h7) begin
                    // Mid-bit sample; abort on false start
                    if (rx_bit_ff == 4'h0 && rxd_lvl_ff) begin
                        nxt_rx_busy = 1'b0;
                    end else if (rx_bit_ff == 4'h9) begin
                        nxt_rx_busy = 1'b0;
                        rx_strobe   = rxd_lvl_ff;
                    end else if (rx_bit_ff != 4'h0) begin
                        nxt_rx_sh = {rxd_lvl_ff, rx_sh_ff[7:1]};
                    end
                    nxt_rx_bit = rx_bit_ff + 4'h1;
                end
            end
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            rx_tick_ff <= 4'h0;
            rx_bit_ff  <= 4'h0;
            rx_sh_ff   <= 8'h00;
            rx_busy_ff <= 1'b0;
        end else begin
            rx_tick_ff <= nxt_rx_tick;
            rx_bit_ff  <= nxt_rx_bit;
            rx_sh_ff   <= nxt_rx_sh;
            rx_busy_ff <= nxt_rx_busy;
        end
    end

    // Two-entry echo buffer; transmitter drains it
    logic [7:0] eb_data_ff [0:1];
    logic [1:0] eb_cnt_ff, nxt_eb_cnt;
    logic       eb_wr, eb_rd, eb_in_ready;
    logic [9:0] tx_sh_ff, nxt_tx_sh;
    logic [3:0] tx_tick_ff, nxt_tx_tick;
    logic [3:0] tx_bit_ff, nxt_tx_bit;
    logic       tx_busy_ff, nxt_tx_busy;
    logic       serial_mode;
    assign eb_in_ready = (eb_cnt_ff != 2'h2);
    assign eb_wr = rx_strobe & serial_mode & eb_in_ready;
    assign eb_rd = (eb_cnt_ff != 2'h0) & ~tx_busy_ff;
    always_comb begin
        nxt_eb_cnt  = eb_cnt_ff + {1'b0, eb_wr} - {1'b0, eb_rd};
        nxt_tx_sh   = tx_sh_ff;
        nxt_tx_tick = tx_tick_ff;
        nxt_tx_bit  = tx_bit_ff;
        nxt_tx_busy = tx_busy_ff;
        if (eb_rd) begin
            nxt_tx_sh   = {1'b1, eb_data_ff[0], 1'b0};
            nxt_tx_busy = 1'b1;
            nxt_tx_tick = 4'h0;
            nxt_tx_bit  = 4'h0;
        end else if (tx_busy_ff && sclk_rise) begin
            nxt_tx_tick = tx_tick_ff + 4'h1;
            if (tx_tick_ff == 4'hf) begin
                nxt_tx_sh  = {1'b1, tx_sh_ff[9:1]};
                nxt_tx_bit = tx_bit_ff + 4'h1;
                if (tx_bit_ff == 4'h9) begin
                    nxt_tx_busy = 1'b0;
                end
            end
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            eb_data_ff[0] <= 8'h00;
            eb_data_ff[1] <= 8'h00;
            eb_cnt_ff     <= 2'h0;
            tx_sh_ff      <= 10'h3ff;
            tx_tick_ff    <= 4'h0;
            tx_bit_ff     <= 4'h0;
            tx_busy_ff    <= 1'b0;
        end else begin
            if (eb_rd) begin
                eb_data_ff[0] <= eb_data_ff[1];
            end
            if (eb_wr) begin
                eb_data_ff[(eb_cnt_ff - {1'b0, eb_rd}) == 2'h0 ? 0 : 1] <= rx_sh_ff;
            end
            eb_cnt_ff  <= nxt_eb_cnt;
            tx_sh_ff   <= nxt_tx_sh;
            tx_tick_ff <= nxt_tx_tick;
            tx_bit_ff  <= nxt_tx_bit;
            tx_busy_ff <= nxt_tx_busy;
        end
    end
    assign serial_txd = tx_sh_ff[0];

    // Loader sequence
    load_state_t state_ff, nxt_state;
    logic [3:0]  mode_ff, nxt_mode;
    logic [23:0] count_ff, nxt_count, addr_ff, nxt_addr, word_ff, nxt_word;
    logic [23:0] wr_ptr_ff, nxt_wr_ptr, ext_addr_ff, nxt_ext_addr;
    logic [1:0]  byte_ff, nxt_byte;
    logic        rd_ff, nxt_rd, early_ff, nxt_early;
    logic [2:0]  capt_ff;
    logic [23:0] start_ff, nxt_start;
    logic        byte_in;
    logic [7:0]  byte_val;
    logic        program_ram_we;
    assign serial_mode = (mode_ff == boot_loader_pkg::MODE_SERIAL);
    assign byte_in  = (mode_ff == boot_loader_pkg::MODE_BYTE_MEM) ? (rd_ff & ext_ack) :
                      serial_mode ? eb_wr : 1'b0;
    assign byte_val = serial_mode ? rx_sh_ff : ext_data[7:0];
    always_comb begin
        nxt_state = state_ff;
        nxt_mode = mode_ff;
        nxt_count = count_ff;
        nxt_addr = addr_ff;
        nxt_word = word_ff;
        nxt_wr_ptr = wr_ptr_ff;
        nxt_ext_addr = ext_addr_ff;
        nxt_byte = byte_ff;
        nxt_rd = 1'b0;
        nxt_early = early_ff;
        nxt_start = start_ff;
        program_ram_we = 1'b0;
        case (state_ff)
            ST_CAPTURE: begin
                if (capt_ff[2]) begin
                    nxt_mode = {sync_mode3_ff[2], sync_mode2_ff[2],
                                sync_mode1_ff[2], sync_mode0_ff[2]};
                    nxt_ext_addr = boot_loader_pkg::BYTE_MEM_BASE;
                    nxt_state = ST_COUNT;
                    nxt_start = boot_loader_pkg::VEC_BOOTSTRAP;
                    if (nxt_mode == boot_loader_pkg::MODE_EXPANDED) begin
                        nxt_start = boot_loader_pkg::VEC_EXPANDED;
                        nxt_state = ST_RUN;
                    end else if (nxt_mode != boot_loader_pkg::MODE_BYTE_MEM &&
                                 nxt_mode != boot_loader_pkg::MODE_SERIAL &&
                                 nxt_mode != boot_loader_pkg::MODE_HOST) begin
                        nxt_start = boot_loader_pkg::VEC_BOOTSTRAP;
                        nxt_state = ST_IDLE;
                    end
                end
            end
            ST_COUNT, ST_ADDR, ST_WORDS: begin
                nxt_rd = (mode_ff == boot_loader_pkg::MODE_BYTE_MEM) & ~(rd_ff & ext_ack);
                if (mode_ff == boot_loader_pkg::MODE_HOST) begin
                    if (hf0_lvl_ff && state_ff == ST_WORDS) begin
                        nxt_early = 1'b1;
                        nxt_start = addr_ff;
                        nxt_state = ST_RUN;
                    end else if (host_valid) begin
                        nxt_word = host_data;
                        nxt_byte = 2'h2;
                    end
                end else if (byte_in) begin
                    nxt_ext_addr = ext_addr_ff + 24'h1;
                    nxt_word = {byte_val, word_ff[23:8]};
                    nxt_byte = (byte_ff == 2'h2) ? 2'h0 : byte_ff + 2'h1;
                end
                if (nxt_state != ST_RUN && ((byte_in && byte_ff == 2'h2) ||
                    (mode_ff == boot_loader_pkg::MODE_HOST && host_valid))) begin
                    nxt_byte = 2'h0;
                    if (state_ff == ST_COUNT) begin
                        nxt_count = nxt_word;
                        nxt_state = ST_ADDR;
                    end else if (state_ff == ST_ADDR) begin
                        nxt_addr = nxt_word;
                        nxt_wr_ptr = nxt_word;
                        nxt_state = (count_ff == 24'h0) ? ST_RUN : ST_WORDS;
                        nxt_start = nxt_word;
                    end else begin
                        program_ram_we = 1'b1;
                        nxt_wr_ptr = wr_ptr_ff + 24'h1;
                        nxt_count = count_ff - 24'h1;
                        if (count_ff == 24'h1) begin
                            nxt_state = ST_RUN;
                        end
                    end
                    if (nxt_state == ST_RUN) begin
                        nxt_start = nxt_addr;
                        nxt_rd = 1'b0;
                    end
                end
            end
            default: begin
            end
        endcase
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            state_ff <= ST_CAPTURE;
            mode_ff <= 4'h0;
            count_ff <= 24'h0;
            addr_ff <= 24'h0;
            word_ff <= 24'h0;
            wr_ptr_ff <= 24'h0;
            ext_addr_ff <= 24'h0;
            byte_ff <= 2'h0;
            rd_ff <= 1'b0;
            early_ff <= 1'b0;
            start_ff <= 24'h0;
            capt_ff <= 3'h0;
        end else begin
            state_ff <= nxt_state;
            mode_ff <= nxt_mode;
            count_ff <= nxt_count;
            addr_ff <= nxt_addr;
            word_ff <= nxt_word;
            wr_ptr_ff <= nxt_wr_ptr;
            ext_addr_ff <= nxt_ext_addr;
            byte_ff <= nxt_byte;
            rd_ff <= nxt_rd;
            early_ff <= nxt_early;
            start_ff <= nxt_start;
            capt_ff <= {capt_ff[1:0], 1'b1}; // Mode pins reach stage three first
        end
    end

    program_ram u_program_ram (
        .clk_sys (clk_sys),
        .wr_en   (program_ram_we),
        .wr_addr (wr_ptr_ff[boot_loader_pkg::PROGRAM_RAM_AW-1:0]),
        .wr_data (nxt_word),
        .rd_addr (wb_adr_i[3:2] == 2'h0 ? count_ff[boot_loader_pkg::PROGRAM_RAM_AW-1:0]
                                       : addr_ff[boot_loader_pkg::PROGRAM_RAM_AW-1:0]),
        .rd_data ()
    );

    // Output registers
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ext_addr <= 24'h0;
            ext_rd <= 1'b0;
            address_attribute_strobe_one <= 1'b0;
            ext_access_type <= boot_loader_pkg::ACC_NONE;
            ext_wait_states <= 5'h0;
            host_ready <= 1'b0;
            host_port_isa <= 1'b0;
            core_run <= 1'b0;
            core_start_addr <= 24'h0;
        end else begin
            ext_addr <= (mode_ff == boot_loader_pkg::MODE_EXPANDED) ? start_ff : nxt_ext_addr;
            ext_rd <= nxt_rd;
            address_attribute_strobe_one <= nxt_rd;
            ext_access_type <= (mode_ff == boot_loader_pkg::MODE_EXPANDED ||
                                mode_ff == boot_loader_pkg::MODE_BYTE_MEM)
                               ? boot_loader_pkg::ACC_SRAM : boot_loader_pkg::ACC_NONE;
            ext_wait_states <= boot_loader_pkg::EXT_WAIT_STATES;
            host_port_isa <= (mode_ff == boot_loader_pkg::MODE_HOST);
            host_ready <= (mode_ff == boot_loader_pkg::MODE_HOST) &&
                          (nxt_state == ST_COUNT || nxt_state == ST_ADDR ||
                           nxt_state == ST_WORDS);
            core_run <= (nxt_state == ST_RUN);
            core_start_addr <= nxt_start;
        end
    end

    // Wishbone read-only status; ack one cycle, then dropped
    logic        ack_ff, nxt_ack;
    logic [31:0] rdat_ff, nxt_rdat;
    always_comb begin
        nxt_ack = wb_cyc_i & wb_stb_i & ~ack_ff;
        nxt_rdat = 32'h0;
        if (wb_adr_i == boot_loader_pkg::REG_STATUS) begin
            nxt_rdat[boot_loader_pkg::ST_DONE_BIT] = (state_ff == ST_RUN);
            nxt_rdat[boot_loader_pkg::ST_MODE_LSB +: 4] = mode_ff;
            nxt_rdat[boot_loader_pkg::ST_EARLY_BIT] = early_ff;
        end else if (wb_adr_i == boot_loader_pkg::REG_VECTOR) begin
            nxt_rdat = {8'h0, start_ff};
        end else if (wb_adr_i == boot_loader_pkg::REG_COUNT) begin
            nxt_rdat = {8'h0, count_ff};
        end else if (wb_adr_i == boot_loader_pkg::REG_LOADADDR) begin
            nxt_rdat = {8'h0, addr_ff};
        end
    end
    always_ff @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            ack_ff <= 1'b0;
            rdat_ff <= 32'h0;
        end else begin
            ack_ff <= nxt_ack;
            rdat_ff <= nxt_rdat;
        end
    end
    assign wb_ack_o = ack_ff;
    assign wb_dat_o = rdat_ff;
endmodule : boot_mode_program_loader
`default_nettype wire

// file: test/boot_loader_chk_sva.sv
// Port assertions for the boot mode program loader
`timescale 1ns/1ps
`default_nettype none
module boot_loader_chk (
    // Clock and reset
    input wire logic        clk_sys,
    input wire logic        rst,
    // Byte memory
    input wire logic [23:0] ext_addr,
    input wire logic        ext_rd,
    input wire logic        ext_ack,
    input wire logic        address_attribute_strobe_one,
    input wire logic [1:0]  ext_access_type,
    input wire logic [4:0]  ext_wait_states,
    // Host and core
    input wire logic        host_ready,
    input wire logic        host_port_isa,
    input wire logic        core_run,
    input wire logic [23:0] core_start_addr,
    // Wishbone
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_ack_o
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    strobe_follows_read_a: assert property (address_attribute_strobe_one == ext_rd)
        else $error("strobe one differs from read");
    byte_read_waits_a: assert property (ext_rd |-> ext_wait_states == 5'h1f
        && ext_access_type == boot_loader_pkg::ACC_SRAM) else $error("read without sram waits");
    read_held_a: assert property (ext_rd && !ext_ack |=> ext_rd && $stable(ext_addr))
        else $error("read dropped before ack");
    addr_step_a: assert property (ext_rd && ext_ack |=> ext_addr == $past(ext_addr) + 24'h1)
        else $error("byte address did not step");
    run_sticky_a: assert property (core_run |=> core_run && $stable(core_start_addr))
        else $error("core run or start moved");
    host_closed_a: assert property (core_run |-> !host_ready)
        else $error("host ready after run");
    isa_no_memory_a: assert property (host_port_isa |-> !ext_rd
        && ext_access_type == boot_loader_pkg::ACC_NONE) else $error("memory used in host mode");
    wb_answer_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("wishbone ack missing");
    wb_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("wishbone ack too long");
    cover property ($rose(core_run) && !host_port_isa);
    cover property ($rose(core_run) && host_port_isa);
    cover property (ext_rd && ext_ack);
endmodule : boot_loader_chk
`default_nettype wire

// file: test/byte_mem_model.sv
// Byte-wide boot memory holding count, address and words
`timescale 1ns/1ps
`default_nettype none
module byte_mem_model #(
    parameter logic [23:0] WORDS = 24'h2,
    parameter logic [23:0] LOAD  = 24'h123,
    parameter int          DELAY = 1
) (
    // Clock
    input wire logic        clk_sys,
    // Memory bus
    input wire logic [23:0] ext_addr,
    input wire logic        ext_rd,
    input wire logic        address_attribute_strobe_one,
    output logic [7:0]      ext_data,
    output logic            ext_ack
);
    int wait_n;
    function automatic logic [7:0] byte_at(input logic [23:0] a);
        logic [23:0] idx;
        logic [23:0] v;
        idx = a / 3;
        v = (idx == 0) ? WORDS : (idx == 1) ? LOAD : {8'hc0, 8'h5a, idx[7:0]};
        return v[8 * (a % 3) +: 8];
    endfunction : byte_at
    // Slow answer on purpose, so read hold is exercised
    always @(posedge clk_sys) begin
        if (ext_rd && address_attribute_strobe_one && !ext_ack && wait_n >= DELAY) begin
            ext_ack  <= 1'h1;
            ext_data <= byte_at(ext_addr - boot_loader_pkg::BYTE_MEM_BASE);
            wait_n   <= 0;
        end else begin
            // Released bus must not keep showing the last byte
            if (ext_ack)
                ext_data <= ~ext_data;
            ext_ack <= 1'h0;
            wait_n  <= (ext_rd && !ext_ack) ? wait_n + 1 : 0;
        end
    end
endmodule : byte_mem_model
`default_nettype wire

// file: test/test_boot_mode_program_loader.sv
// Self-checking bench for the boot mode program loader
`timescale 1ns/1ps
`default_nettype none
module test_boot_mode_program_loader;
    typedef struct packed {
        logic [3:0]  mode;
        logic [23:0] vec;
        logic        isa;
        logic [1:0]  acc;
    } row_t;
    localparam logic [23:0] LOAD = 24'h000123;
    localparam row_t ROWS [5] = '{'{4'h8, 24'h008000, 1'h0, 2'h1}, '{4'h9, 24'hff0000, 1'h0, 2'h1},
        '{4'ha, 24'hff0000, 1'h0, 2'h0}, '{4'hc, 24'hff0000, 1'h1, 2'h0},
        '{4'hb, 24'hff0000, 1'h0, 2'h0}};
    logic        clk_sys, rst, ext_rd, aa1, ext_ack, txd, host_valid, host_ready, flag0, isa;
    logic        core_run, wb_cyc, wb_stb, wb_we, wb_ack, sclk, rxd;
    logic [3:0]  mode_pins, wb_adr;
    logic [1:0]  acc;
    logic [4:0]  waits;
    logic [7:0]  ext_data;
    logic [23:0] ext_addr, host_data, start;
    logic [31:0] wb_rd, rd;
    int          n_errors, checked;

    boot_mode_program_loader DUT (.clk_sys(clk_sys), .rst(rst),
        .mode_select_bit0(mode_pins[0]), .mode_select_bit1(mode_pins[1]),
        .mode_select_bit2(mode_pins[2]), .mode_select_bit3(mode_pins[3]),
        .ext_addr(ext_addr), .ext_rd(ext_rd), .address_attribute_strobe_one(aa1),
        .ext_access_type(acc), .ext_wait_states(waits), .ext_data(ext_data), .ext_ack(ext_ack),
        .serial_clk(sclk), .serial_rxd(rxd), .serial_txd(txd),
        .host_data(host_data), .host_valid(host_valid), .host_ready(host_ready),
        .host_flag_zero(flag0), .host_port_isa(isa), .core_run(core_run), .core_start_addr(start),
        .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb), .wb_we_i(wb_we), .wb_adr_i(wb_adr),
        .wb_dat_i(32'hffffffff), .wb_sel_i(4'hf), .wb_dat_o(wb_rd), .wb_ack_o(wb_ack));
    byte_mem_model #(.WORDS(24'h2), .LOAD(LOAD), .DELAY(1)) u_mem (.clk_sys(clk_sys),
        .ext_addr(ext_addr), .ext_rd(ext_rd), .address_attribute_strobe_one(aa1),
        .ext_data(ext_data), .ext_ack(ext_ack));

    task automatic test_done();
        if (n_errors == 0 && checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : test_done
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic wb(input logic we, input logic [3:0] adr, output logic [31:0] dat);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we  <= we;
        wb_adr <= adr;
        do @(posedge clk_sys); while (wb_ack !== 1'h1);
        dat = wb_rd;
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        @(posedge clk_sys);
    endtask : wb
    task automatic boot(input logic [3:0] m);
        rst       <= 1'h1;
        mode_pins <= m;
        repeat (16) @(posedge clk_sys);
        rst <= 1'h0;
        repeat (8) @(posedge clk_sys);
    endtask : boot
    task automatic wait_run();
        for (int i = 0; i < 2000 && core_run !== 1'h1; i++)
            @(posedge clk_sys);
    endtask : wait_run
    // Hang on a missing ready is cut by the watchdog
    task automatic host_put(input logic [23:0] d);
        host_data  <= d;
        host_valid <= 1'h1;
        do @(posedge clk_sys); while (host_ready !== 1'h1);
        host_valid <= 1'h0;
        @(posedge clk_sys);
    endtask : host_put
    // Sixteen serial clocks per bit, slow enough for the pin synchronisers
    task automatic ser_put(input logic [9:0] f);
        for (int i = 0; i < 320; i++) begin
            rxd  <= f[i / 32];
            sclk <= i[0];
            repeat (2) @(posedge clk_sys);
        end
    endtask : ser_put

    initial begin
        clk_sys = 1'h0;
        forever #20 clk_sys = ~clk_sys;
    end
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        test_done();
    end
    initial begin
        rst = 1'h1;
        mode_pins = 4'h0;
        host_data = 24'h0;
        host_valid = 1'h0;
        flag0 = 1'h0;
        sclk = 1'h0;
        rxd = 1'h1;
        wb_cyc = 1'h0;
        wb_stb = 1'h0;
        wb_we = 1'h0;
        wb_adr = 4'h0;
        foreach (ROWS[k]) begin
            boot(ROWS[k].mode);
            chk("isa", ROWS[k].isa, isa);
            chk("access", ROWS[k].acc, acc);
            chk("waits", boot_loader_pkg::EXT_WAIT_STATES, waits);
            wb(1'h0, boot_loader_pkg::REG_VECTOR, rd);
            chk("vector", ROWS[k].vec, rd);
        end
        wb(1'h1, boot_loader_pkg::REG_VECTOR, rd);
        wb(1'h0, boot_loader_pkg::REG_VECTOR, rd);
        chk("vector kept", 32'hff0000, rd);
        wb(1'h0, 4'h2, rd);
        chk("unmapped", 32'h0, rd);
        boot(4'h9);
        wait_run();
        chk("byte run", 32'h1, core_run);
        chk("byte start", LOAD, start);
        chk("bytes used", boot_loader_pkg::BYTE_MEM_BASE + 24'hc, ext_addr);
        wb(1'h0, boot_loader_pkg::REG_LOADADDR, rd);
        chk("load addr", LOAD, rd);
        wb(1'h0, boot_loader_pkg::REG_COUNT, rd);
        chk("count left", 32'h0, rd);
        wb(1'h0, boot_loader_pkg::REG_STATUS, rd);
        chk("byte status", 32'h91, rd);
        boot(4'ha);
        for (int j = 0; j < 6; j++)
            ser_put({1'h1, j < 3 ? 8'h00 : 8'(j), 1'h0});
        wait_run();
        chk("serial start", 32'h050403, start);
        boot(4'hc);
        host_put(24'h000003);
        host_put(24'h000045);
        host_put(24'habcdef);
        host_put(24'h123456);
        chk("host early", 32'h0, core_run);
        flag0 <= 1'h1;
        wait_run();
        chk("host run", 32'h1, core_run);
        chk("host start", 32'h45, start);
        wb(1'h0, boot_loader_pkg::REG_COUNT, rd);
        chk("host left", 32'h1, rd);
        wb(1'h0, boot_loader_pkg::REG_STATUS, rd);
        chk("host status", 32'h1c1, rd);
        test_done();
    end
endmodule : test_boot_mode_program_loader
bind boot_mode_program_loader boot_loader_chk u_chk (.clk_sys, .rst, .ext_addr, .ext_rd,
    .ext_ack, .address_attribute_strobe_one, .ext_access_type, .ext_wait_states, .host_ready,
    .host_port_isa, .core_run, .core_start_addr, .wb_cyc_i, .wb_stb_i, .wb_ack_o);
`default_nettype wire
